// ---- bench/epi_core_model.sv ----
// Core-side model: answers interrupt requests with a delayed handler ack
`default_nettype none
module epi_core_model (
    // Clock
    input  wire logic       clk,
    // Requests and control
    input  wire logic [2:0] irq,
    input  wire logic       ack_en,
    input  wire logic [7:0] delay,
    // Handler acknowledges, one pulse each
    output logic      [2:0] ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [3];
    initial ack = 3'h0;
    // Count the request, then enter the handler once; slow or prompt
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            ack[i] <= 1'b0;
            if (ack_en !== 1'b1 || irq[i] !== 1'b1) begin
                cnt[i] <= 0;
            end else if (cnt[i] == int'(delay)) begin
                ack[i] <= 1'b1;
                cnt[i] <= 0;
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule : epi_core_model
`default_nettype wire

// ---- bench/external_pin_interrupts_tb.sv ----
// Register and pin tests of the pin interrupt unit
`include "epi_regs.svh"
`default_nettype none
module external_pin_interrupts_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_CTRL = {`EPI_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_MASK = {`EPI_IDX_MASK, 2'b00};
    localparam logic [7:0] A_FLAG = {`EPI_IDX_FLAG, 2'b00};
    localparam logic [7:0] A_PCML = {`EPI_IDX_PCML, 2'b00};
    localparam logic [7:0] A_PCMH = {`EPI_IDX_PCMH, 2'b00};
    localparam int         PIN [6] = '{3, 12, 8, 8, 0, 13};
    localparam logic [7:0] PM [6] = '{8'h20, 8'h20, 8'h20, 8'h10, 8'h30,
                                      8'h10};
    localparam logic       EX [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        gie, io_run, ack_en, pullup_disable, slen;
    logic        wake;
    logic [1:0]  bresp, rresp, ext, smode, r;
    logic [2:0]  irq, ack;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr, dly;
    logic [15:0] pci;
    logic [31:0] wdata, rdata, d;
    int          fails, n_tests;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and core model
    always #12.5 clk = ~clk;
    epi_top i_dut (
        .CORE_CLK(clk), .RST_B(rst_b),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .EXT_IRQ_PIN(ext), .PIN_CHANGE_INPUTS(pci), .GLOBAL_IRQ_EN(gie),
        .IO_CLK_RUN(io_run), .ACK_EXT0(ack[0]), .ACK_EXT1(ack[1]),
        .ACK_PC(ack[2]), .IRQ_EXT0(irq[0]), .IRQ_EXT1(irq[1]),
        .IRQ_PC(irq[2]), .WAKE_REQ(wake), .PULLUP_DISABLE(pullup_disable),
        .SLEEP_ENABLE(slen), .SLEEP_MODE(smode));
    epi_core_model i_core (.clk(clk), .irq(irq), .ack_en(ack_en),
        .delay(dly), .ack(ack));

    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict, waits
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
    endtask : wt
    // Pins may be driven as outputs by software; the unit still sees them
    task automatic setx(input logic [1:0] v);
        @(posedge clk);
        ext <= v;
    endtask : setx

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite master; each valid holds until its own ready edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      output logic [1:0] rsp);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        rsp = bresp;
        bready <= 1'b0;
        if (n >= 100) begin
            fails++;
            summarize();
        end
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        d = rdata;
        rready <= 1'b0;
        if (n >= 100) begin
            fails++;
            summarize();
        end
        chk(d, exp);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {clk, rst_b, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {gie, ack_en, io_run} = 3'h1;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        dly = 8'h14;
        ext = 2'h3;
        pci = 16'h0;
        fails = 0;
        n_tests = 0;
        wt(10);
        rst_b <= 1'b1;
        wt(2);
        // Reset values and read-only bits
        rdchk(A_CTRL, 32'h0);
        rdchk(A_MASK, 32'h0);
        rdchk(A_PCML, 32'hc8);
        rdchk(A_PCMH, 32'hff);
        wr(A_CTRL, 8'hff, r);
        rdchk(A_CTRL, 32'h7b);
        chk({28'h0, pullup_disable, slen, smode}, 32'hf);
        wr(A_MASK, 8'hff, r);
        rdchk(A_MASK, 32'hf0);
        // Reset in mid-run brings written registers back to zero
        rst_b <= 1'b0;
        wt(3);
        rst_b <= 1'b1;
        wt(2);
        rdchk(A_CTRL, 32'h0);
        rdchk(A_MASK, 32'h0);
        chk({28'h0, pullup_disable, slen, smode}, 32'h0);
        wr(8'hfc, 8'h01, r);
        chk({30'h0, r}, {30'h0, `EPI_RESP_SLVERR});
        rdchk(8'hfc, 32'h0);
        chk({30'h0, rresp}, {30'h0, `EPI_RESP_SLVERR});
        // Every edge mode on both pins, fall then rise
        wr(A_MASK, 8'hc0, r);
        gie <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
                wr(A_CTRL, m[7:0], r);
                wr(A_FLAG, 8'he0, r);
                setx(2'b11 ^ (2'b01 << p));
                wt(8);
                chk({31'h0, irq[p]}, {31'h0, m != 3});
                wr(A_FLAG, 8'he0, r);
                setx(2'b11);
                wt(8);
                chk({31'h0, irq[p]}, {31'h0, m != 2});
                wr(A_FLAG, 8'he0, r);
            end
        end
        // Pin one masked off: flag sets, request held back
        wr(A_MASK, 8'h40, r);
        setx(2'b01);
        wt(4);
        setx(2'b11);
        wt(8);
        rdchk(A_FLAG, 32'h80);
        chk({31'h0, irq[1]}, 32'h0);
        gie <= 1'b0;
        wr(A_MASK, 8'hc0, r);
        chk({31'h0, irq[1]}, 32'h0);
        gie <= 1'b1;
        wt(3);
        chk({31'h0, irq[1]}, 32'h1);
        wr(A_FLAG, 8'h80, r);
        rdchk(A_FLAG, 32'h0);
        // Halted I/O clock hides a falling edge
        wr(A_CTRL, 8'h02, r);
        io_run <= 1'b0;
        setx(2'b10);
        wt(8);
        chk({31'h0, irq[0]}, 32'h0);
        setx(2'b11);
        wt(4);
        io_run <= 1'b1;
        wt(4);
        chk({31'h0, irq[0]}, 32'h0);
        // Low level without clock: request and wake while held low
        wr(A_CTRL, 8'h00, r);
        io_run <= 1'b0;
        setx(2'b10);
        wt(8);
        chk({30'h0, wake, irq[0]}, 32'h3);
        wt(20);
        chk({31'h0, irq[0]}, 32'h1);
        rdchk(A_FLAG, 32'h0);
        gie <= 1'b0;
        wt(3);
        chk({30'h0, wake, irq[0]}, 32'h2);
        gie <= 1'b1;
        setx(2'b11);
        wt(8);
        chk({30'h0, wake, irq[0]}, 32'h0);
        io_run <= 1'b1;
        // Handler entry clears the flag
        wr(A_CTRL, 8'h01, r);
        ack_en <= 1'b1;
        setx(2'b01);
        wt(8);
        chk({31'h0, irq[1]}, 32'h1);
        wt(40);
        chk({31'h0, irq[1]}, 32'h0);
        setx(2'b11);
        wt(48);
        ack_en <= 1'b0;
        rdchk(A_FLAG, 32'h0);
        // Pin change groups and masks, clock halted
        io_run <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(A_MASK, PM[i], r);
            wr(A_FLAG, 8'he0, r);
            pci <= pci ^ (16'h1 << PIN[i]);
            wt(8);
            chk({31'h0, irq[2]}, {31'h0, EX[i]});
        end
        summarize();
    end
    // Hang guard
    initial begin
        wt(60000);
        fails++;
        summarize();
    end
endmodule : external_pin_interrupts_tb
`default_nettype wire

// ---- design/epi_sync.sv ----
// Two-stage synchroniser for a group of pin inputs
`default_nettype none
module epi_sync #(
    parameter int W = 18
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Raw and synchronised levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // First stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_ff <= '1;
            q       <= '1;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : epi_sync
`default_nettype wire

// ---- design/epi_top.sv ----
// Pin interrupt unit: sense control, pin change, flags, AXI4-Lite slave
//
// Overview of operation
// - Pin activity raises interrupts even when the pin drives an output.
// - Pin change requested when any masked pin-change input toggles.
// - Pin-change detection works without the I/O clock, for wake-up.
// - Enabled low-level pin requests interrupt for as long as it stays low.
// - Edge detection needs the running I/O clock; none while halted.
// - Low level on pin zero is detected without the I/O clock.
// - Low level gone before start-up: wake, but no interrupt; here a short low still raises IRQ_EXT0 while the global enable is set.
// - Pins are sampled first; pulses over one clock make a request.
// - Sense select bits 1:0: low, any change, falling, rising.
// - Control holds pull-up off, sleep enable, sleep mode; 7,2 zero.
// - Mask bit 7 plus global enable requests external interrupt one.
// - Mask bit 6 plus global enable requests external interrupt zero.
// - Bit 5 group enables pin change on inputs 7:0 and 15:12.
// - Mask register bits 3:0 read zero; all bits reset to zero.
// - Bit 4 group enables pin change on inputs 11:8.
// - Flags set on trigger, clear by ack or write one; external flags clear in level.
//
// Added by the designer: the AXI4-Lite slave port.
`include "epi_regs.svh"
`default_nettype none
module epi_top (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    // AXI4-Lite write channels
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read channels
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Pins
    input  wire logic [1:0]  EXT_IRQ_PIN,
    input  wire logic [15:0] PIN_CHANGE_INPUTS,
    // Core side
    input  wire logic        GLOBAL_IRQ_EN,
    input  wire logic        IO_CLK_RUN,
    input  wire logic        ACK_EXT0,
    input  wire logic        ACK_EXT1,
    input  wire logic        ACK_PC,
    output logic             IRQ_EXT0,
    output logic             IRQ_EXT1,
    output logic             IRQ_PC,
    output logic             WAKE_REQ,
    output logic             PULLUP_DISABLE,
    output logic             SLEEP_ENABLE,
    output logic [1:0]       SLEEP_MODE
);
    ////////////////////////////////////////////////////////////////////////
    epi_pkg::epi_state_t st_ff;
    epi_pkg::epi_state_t nxt_st;
    logic [17:0]         pins_s;
    logic [1:0]          ext_s;
    logic [15:0]         pc_s;
    epi_pkg::epi_sense_t sense;
    logic [1:0]          ext_trig;
    logic [15:0]         pc_en;
    logic                pc_hit;
    logic [7:0]          flag_clr;
    epi_pkg::epi_sel_t   wsel;

    // Address decode, shared by the read and write paths
    function automatic epi_pkg::epi_sel_t decode(input logic [7:0] a);
        logic [5:0] idx;
        idx = a[7:2];
        if (a[1:0] != 2'b00) return epi_pkg::SEL_NONE;
        unique case (idx)
            `EPI_IDX_CTRL: return epi_pkg::SEL_CTRL;
            `EPI_IDX_MASK: return epi_pkg::SEL_MASK;
            `EPI_IDX_FLAG: return epi_pkg::SEL_FLAG;
            `EPI_IDX_PCML: return epi_pkg::SEL_PCML;
            `EPI_IDX_PCMH: return epi_pkg::SEL_PCMH;
            default:       return epi_pkg::SEL_NONE;
        endcase
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    // Pad levels are read straight, whatever the port direction is
    epi_sync #(.W(18)) u_sync (
        .clk   (CORE_CLK),
        .rst_b (RST_B),
        .d     ({EXT_IRQ_PIN, PIN_CHANGE_INPUTS}),
        .q     (pins_s)
    );
    assign ext_s = pins_s[17:16];
    assign pc_s  = pins_s[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Edge recognition per external pin, only while the I/O clock runs
    assign sense = epi_pkg::epi_sense_t'(st_ff.ctrl[`EPI_B_SENSE +: 2]);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_edge
            logic rise;
            logic fall;
            assign rise = ext_s[gi] & ~st_ff.ext_prev[gi];
            assign fall = ~ext_s[gi] & st_ff.ext_prev[gi];
            always_comb begin
                unique case (sense)
                    epi_pkg::SENSE_LOW:  ext_trig[gi] = 1'b0;
                    epi_pkg::SENSE_ANY:
                        ext_trig[gi] = IO_CLK_RUN & (rise | fall);
                    epi_pkg::SENSE_FALL: ext_trig[gi] = IO_CLK_RUN & fall;
                    epi_pkg::SENSE_RISE: ext_trig[gi] = IO_CLK_RUN & rise;
                endcase
            end
        end
    endgenerate

    // Group enables per pin: middle group covers 11:8, main the rest
    assign pc_en = {{4{st_ff.mask[`EPI_B_PCMAIN]}},
                    {4{st_ff.mask[`EPI_B_PCMID]}},
                    {8{st_ff.mask[`EPI_B_PCMAIN]}}};
    // Runs without the I/O clock, so pin change can wake any sleep mode
    assign pc_hit = |((pc_s ^ st_ff.pc_prev) & {st_ff.pcmh, st_ff.pcml}
                      & pc_en);

    // Write decode and one-to-clear mask of the pending write
    assign wsel = decode(st_ff.waddr);
    assign flag_clr = (st_ff.aw_got && st_ff.w_got && !st_ff.bvld &&
                       st_ff.wstb && wsel == epi_pkg::SEL_FLAG) ?
                      (st_ff.wdata & `EPI_FLAG_WMASK) : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for everything
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ext_prev = ext_s;
        nxt_st.pc_prev  = pc_s;

        // Write address and data, taken in either order
        if (S_AXI_AWVALID && st_ff.awrdy) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && st_ff.wrdy) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = S_AXI_WDATA[7:0];
            nxt_st.wstb  = S_AXI_WSTRB[0];
        end
        if (st_ff.bvld && S_AXI_BREADY) begin
            nxt_st.bvld = 1'b0;
        end
        // Commit once both halves are held; upper lanes carry nothing
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvld) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvld   = 1'b1;
            nxt_st.bresp  = `EPI_RESP_OKAY;
            if (st_ff.wstb) begin
                unique case (wsel)
                    epi_pkg::SEL_CTRL:
                        nxt_st.ctrl = st_ff.wdata & `EPI_CTRL_WMASK;
                    epi_pkg::SEL_MASK:
                        nxt_st.mask = st_ff.wdata & `EPI_MASK_WMASK;
                    epi_pkg::SEL_PCML: nxt_st.pcml = st_ff.wdata;
                    epi_pkg::SEL_PCMH: nxt_st.pcmh = st_ff.wdata;
                    epi_pkg::SEL_FLAG: nxt_st.flag = st_ff.flag;
                    epi_pkg::SEL_NONE: nxt_st.bresp = `EPI_RESP_SLVERR;
                endcase
            end else if (wsel == epi_pkg::SEL_NONE) begin
                nxt_st.bresp = `EPI_RESP_SLVERR;
            end
        end
        nxt_st.awrdy = !nxt_st.aw_got && !nxt_st.bvld;
        nxt_st.wrdy  = !nxt_st.w_got && !nxt_st.bvld;

        // Read channel: one read under way at a time
        if (st_ff.rvld && S_AXI_RREADY) begin
            nxt_st.rvld = 1'b0;
        end
        if (S_AXI_ARVALID && st_ff.arrdy) begin
            nxt_st.rvld  = 1'b1;
            nxt_st.rresp = `EPI_RESP_OKAY;
            unique case (decode(S_AXI_ARADDR))
                epi_pkg::SEL_CTRL: nxt_st.rdata = st_ff.ctrl;
                epi_pkg::SEL_MASK: nxt_st.rdata = st_ff.mask;
                epi_pkg::SEL_FLAG: nxt_st.rdata = st_ff.flag;
                epi_pkg::SEL_PCML: nxt_st.rdata = st_ff.pcml;
                epi_pkg::SEL_PCMH: nxt_st.rdata = st_ff.pcmh;
                epi_pkg::SEL_NONE: begin
                    nxt_st.rdata = 8'h00;
                    nxt_st.rresp = `EPI_RESP_SLVERR;
                end
            endcase
        end
        nxt_st.arrdy = !nxt_st.rvld;

        // Flags: a trigger in the clearing cycle wins over the clear
        nxt_st.flag[`EPI_B_FLG0] = ext_trig[0] |
            (st_ff.flag[`EPI_B_FLG0] & ~ACK_EXT0 &
             ~flag_clr[`EPI_B_FLG0]);
        nxt_st.flag[`EPI_B_FLG1] = ext_trig[1] |
            (st_ff.flag[`EPI_B_FLG1] & ~ACK_EXT1 &
             ~flag_clr[`EPI_B_FLG1]);
        nxt_st.flag[`EPI_B_FLGPC] = pc_hit |
            (st_ff.flag[`EPI_B_FLGPC] & ~ACK_PC &
             ~flag_clr[`EPI_B_FLGPC]);
        // Level sensing keeps both external flags clear
        if (sense == epi_pkg::SENSE_LOW) begin
            nxt_st.flag[`EPI_B_FLG0] = 1'b0;
            nxt_st.flag[`EPI_B_FLG1] = 1'b0;
        end

        // Requests: level asks while low, with no clock needed for it
        nxt_st.irq0 = GLOBAL_IRQ_EN & st_ff.mask[`EPI_B_EN0] &
            ((sense == epi_pkg::SENSE_LOW) ? ~ext_s[0] :
             st_ff.flag[`EPI_B_FLG0]);
        nxt_st.irq1 = GLOBAL_IRQ_EN & st_ff.mask[`EPI_B_EN1] &
            ((sense == epi_pkg::SENSE_LOW) ? ~ext_s[1] :
             st_ff.flag[`EPI_B_FLG1]);
        nxt_st.irqpc = GLOBAL_IRQ_EN & (st_ff.mask[`EPI_B_PCMAIN] |
            st_ff.mask[`EPI_B_PCMID]) & st_ff.flag[`EPI_B_FLGPC];

        // Wake does not need the global enable; a short low requests as well as wakes
        nxt_st.wake = (st_ff.mask[`EPI_B_EN0] & ~ext_s[0] &
                       (sense == epi_pkg::SENSE_LOW))
                      | pc_hit;

        // Synchronous reset to documented values
        if (!RST_B) begin
            nxt_st = '0;
            nxt_st.ctrl    = `EPI_RST_CTRL;
            nxt_st.mask    = `EPI_RST_MASK;
            nxt_st.flag    = `EPI_RST_FLAG;
            nxt_st.pcml    = `EPI_RST_PCML;
            nxt_st.pcmh    = `EPI_RST_PCMH;
            nxt_st.pc_prev = 16'hffff;
            nxt_st.ext_prev = 2'h3;
        end
    end

    // State register
    always_ff @(posedge CORE_CLK) begin
        st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from state flops
    assign S_AXI_AWREADY  = st_ff.awrdy;
    assign S_AXI_WREADY   = st_ff.wrdy;
    assign S_AXI_BVALID   = st_ff.bvld;
    assign S_AXI_BRESP    = st_ff.bresp;
    assign S_AXI_ARREADY  = st_ff.arrdy;
    assign S_AXI_RVALID   = st_ff.rvld;
    assign S_AXI_RRESP    = st_ff.rresp;
    assign S_AXI_RDATA    = {24'h000000, st_ff.rdata};
    assign IRQ_EXT0       = st_ff.irq0;
    assign IRQ_EXT1       = st_ff.irq1;
    assign IRQ_PC         = st_ff.irqpc;
    assign WAKE_REQ       = st_ff.wake;
    assign PULLUP_DISABLE = st_ff.ctrl[`EPI_B_PUD];
    assign SLEEP_ENABLE   = st_ff.ctrl[`EPI_B_SLEN];
    assign SLEEP_MODE     = st_ff.ctrl[`EPI_B_SLMODE +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    level_request_a: assert property (
        GLOBAL_IRQ_EN && st_ff.mask[`EPI_B_EN0] && !ext_s[0] &&
        sense == epi_pkg::SENSE_LOW |=> IRQ_EXT0)
        else $error("low level did not request interrupt zero");
    level_flag_clr_a: assert property (
        sense == epi_pkg::SENSE_LOW |=> st_ff.flag[7:6] == 2'b00)
        else $error("external flag set in level mode");
    edge_halted_a: assert property (
        !IO_CLK_RUN && !st_ff.flag[`EPI_B_FLG0]
        |=> !st_ff.flag[`EPI_B_FLG0])
        else $error("edge recognised with I/O clock halted");
    fall_edge_a: assert property (
        IO_CLK_RUN && sense == epi_pkg::SENSE_FALL &&
        st_ff.ext_prev[1] && !ext_s[1] |=> st_ff.flag[`EPI_B_FLG1])
        else $error("falling edge missed on pin one");
    pulse_seen_a: assert property (
        IO_CLK_RUN && sense == epi_pkg::SENSE_ANY &&
        $changed(ext_s[0]) |=> st_ff.flag[`EPI_B_FLG0])
        else $error("pin change not flagged in any-change mode");
    pc_wake_a: assert property (
        pc_hit |=> WAKE_REQ && st_ff.flag[`EPI_B_FLGPC])
        else $error("pin change did not wake or flag");
    ctrl_zero_a: assert property (
        st_ff.ctrl[7] == 1'b0 && st_ff.ctrl[2] == 1'b0)
        else $error("reserved control bits set");
    mask_zero_a: assert property (
        st_ff.mask[3:0] == 4'h0)
        else $error("reserved mask bits set");
    irq_one_gate_a: assert property (
        $rose(IRQ_EXT1) |-> $past(GLOBAL_IRQ_EN) && $past(st_ff.mask[7]))
        else $error("interrupt one without enables");
    irq_zero_gate_a: assert property (
        $rose(IRQ_EXT0) |-> $past(GLOBAL_IRQ_EN) && $past(st_ff.mask[6]))
        else $error("interrupt zero without enables");
    wake_level_a: assert property (
        st_ff.mask[6] && !ext_s[0] && sense == epi_pkg::SENSE_LOW &&
        !IO_CLK_RUN |=> WAKE_REQ)
        else $error("low level on pin zero did not wake");
    bus_answer_a: assert property (
        st_ff.aw_got && st_ff.w_got && !st_ff.bvld |=> S_AXI_BVALID
        ##0 !S_AXI_AWREADY [*1])
        else $error("write response late");
    read_answer_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    rise_edge_a: assert property (
        IO_CLK_RUN && sense == epi_pkg::SENSE_RISE &&
        !st_ff.ext_prev[0] && ext_s[0] |=> st_ff.flag[`EPI_B_FLG0])
        else $error("rising edge missed on pin zero");
    irq_pc_gate_a: assert property (
        $rose(IRQ_PC) |-> $past(GLOBAL_IRQ_EN) &&
        ($past(st_ff.mask[`EPI_B_PCMAIN]) || $past(st_ff.mask[`EPI_B_PCMID])))
        else $error("pin change request without enables");
    pc_group_off_a: assert property (
        !st_ff.mask[`EPI_B_PCMAIN] && !st_ff.mask[`EPI_B_PCMID] &&
        !st_ff.flag[`EPI_B_FLGPC] |=> !st_ff.flag[`EPI_B_FLGPC])
        else $error("pin change flagged with both groups off");

    cover_edge_c:  cover property (IRQ_EXT0 && sense != epi_pkg::SENSE_LOW);
    cover_pc_c:    cover property (IRQ_PC ##1 !IRQ_PC);
    cover_wake_c:  cover property (WAKE_REQ && !IO_CLK_RUN);
    cover_rise_c:  cover property (IRQ_EXT1 && sense == epi_pkg::SENSE_RISE);
    cover_err_c:   cover property (S_AXI_RVALID && S_AXI_RRESP[1]);
endmodule : epi_top
`default_nettype wire

// ---- inc/epi_pkg.sv ----
// Types shared by the pin interrupt unit
`default_nettype none
package epi_pkg;
    // Sense select encoding
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } epi_sense_t;

    // Register selected by an address
    typedef enum {SEL_NONE, SEL_CTRL, SEL_MASK, SEL_FLAG, SEL_PCML,
                  SEL_PCMH} epi_sel_t;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  mask;
        logic [7:0]  flag;
        logic [7:0]  pcml;
        logic [7:0]  pcmh;
        logic [1:0]  ext_prev;
        logic [15:0] pc_prev;
        logic        irq0;
        logic        irq1;
        logic        irqpc;
        logic        wake;
        logic        awrdy;
        logic        wrdy;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  waddr;
        logic [7:0]  wdata;
        logic        wstb;
        logic        bvld;
        logic [1:0]  bresp;
        logic        arrdy;
        logic        rvld;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
    } epi_state_t;
endpackage : epi_pkg
`default_nettype wire

// ---- inc/epi_regs.svh ----
// Register indices, field positions, reset values for the pin interrupt unit
`ifndef EPI_REGS_SVH
`define EPI_REGS_SVH
// Register indices; byte address is four times the index
`define EPI_IDX_CTRL    6'h35
`define EPI_IDX_MASK    6'h3b
`define EPI_IDX_FLAG    6'h3a
`define EPI_IDX_PCML    6'h23
`define EPI_IDX_PCMH    6'h22
// Reset values
`define EPI_RST_CTRL    8'h00
`define EPI_RST_MASK    8'h00
`define EPI_RST_FLAG    8'h00
`define EPI_RST_PCML    8'hc8
`define EPI_RST_PCMH    8'hff
// Writable bits; everything else reads zero
`define EPI_CTRL_WMASK  8'h7b
`define EPI_MASK_WMASK  8'hf0
`define EPI_FLAG_WMASK  8'he0
// Control register fields
`define EPI_B_SENSE     0
`define EPI_B_SLMODE    3
`define EPI_B_SLEN      5
`define EPI_B_PUD       6
// Enable mask fields
`define EPI_B_EN1       7
`define EPI_B_EN0       6
`define EPI_B_PCMAIN    5
`define EPI_B_PCMID     4
// Flag register fields
`define EPI_B_FLG1      7
`define EPI_B_FLG0      6
`define EPI_B_FLGPC     5
// Bus responses
`define EPI_RESP_OKAY   2'b00
`define EPI_RESP_SLVERR 2'b10
`endif
